// [logic/ptd_decoder.sv]
// Paper tape format decoder: tape reader to buffer, duplicate and compare
`timescale 1ns/1ns
// Notes on behaviour
// - Four step drives, eight data, one sprocket.
// - Own incrementing address from start address; record format loads the record address.
// - Hex 8-bit: two hex chars per word.
// - Hex 4-bit: low nibble only, high kept.
// - Hex: skip header until asterisk.
// - Hex: slash ends read early.
// - Letter 8-bit: B, eight P/N, F.
// - Letter 4-bit: B, four P/N, F.
// - Binary 8-bit: each char one word.
// - Binary 4-bit: low four bits only.
// - Binary: skip header until delete.
// - Binary: no end char, run to end.
// - Record starts at colon, skip before.
// - Two hex digits give byte count.
// - Four hex digits give load address.
// - Two hex digits give record type.
// - Hex pairs after type are data.
// - Checksum: bytes sum zero modulo 256.
// - Count used up: seek next colon.
// - Checksum fail in duplicate: show error code.
// - Mismatch: show address, data, wait enter.
// - Codes 00/02/04/06 select duplicate.
// - Codes 01/03/05/07 select compare.
module ptd_decoder (
  // Clocks and reset
  input wire logic CLOCK_I,
  input wire logic RST_N_I,
  input wire logic TAPE_CLK_I,
  // Tape reader link
  input wire logic SPROCKET_I,
  input wire logic [7:0] TAPE_DATA_I,
  output logic [3:0] STEP_DRIVE_O,
  // Front panel
  input wire logic START_I,
  input wire logic ENTER_I,
  input wire logic [7:0] FORMAT_I,
  input wire logic NIBBLE_MODE_I,
  input wire logic AUDIO_EN_I,
  input wire logic [15:0] START_ADDR_I,
  input wire logic [15:0] END_ADDR_I,
  output logic BUSY_O,
  output logic DONE_O,
  output logic CMP_PAUSE_O,
  output logic [15:0] SHOW_ADDR_O,
  output logic [7:0] SHOW_DATA_O,
  output logic [7:0] ERROR_CODE_O,
  output logic WARBLE_O,
  // Buffer RAM
  output logic [15:0] BUF_ADDR_O,
  output logic [7:0] BUF_WDATA_O,
  output logic BUF_WE_O,
  input wire logic [7:0] BUF_RDATA_I
);
  logic link_tgl;
  logic [7:0] link_char;
  logic tgl_s, tgl_d_reg, enter_s, enter_d_reg, start_s, start_d_reg;
  logic [7:0] ch_reg;
  logic ch_vld_reg;
  ptd_pkg::ptd_state_t st_reg;
  ptd_pkg::ptd_rec_t rs_reg;
  logic [2:0] fmt_reg;
  logic cmp_reg, nib_reg;
  logic [15:0] addr_reg, end_reg;
  logic [7:0] acc_reg, sum_reg, cnt_reg;
  logic [3:0] pos_reg;
  logic half_reg, inword_reg;
  logic [7:0] exp_reg;
  logic pend_cmp_reg, pend_wr_reg;
  logic [ptd_pkg::CNT_W-1:0] step_cnt_reg;

  function automatic logic is_hex(input logic [7:0] c);
    return (c >= 8'h30 && c <= 8'h39) || (c >= 8'h41 && c <= 8'h46) ||
      (c >= 8'h61 && c <= 8'h66);
  endfunction

  function automatic logic [3:0] hex_val(input logic [7:0] c);
    logic [7:0] v;
    v = 8'h00;
    if (c <= 8'h39)
      v = c - 8'h30;
    else if (c <= 8'h46)
      v = c - 8'h37;
    else
      v = c - 8'h57;
    return v[3:0];
  endfunction

  // Tape link sampled on its own clock
  ptd_link u_link (
    .link_clk_i(TAPE_CLK_I),
    .rst_n_i(RST_N_I),
    .sprocket_i(SPROCKET_I),
    .data_i(TAPE_DATA_I),
    .tgl_o(link_tgl),
    .char_o(link_char)
  );

  ptd_sync #(.W(3)) u_sync (
    .clk_i(CLOCK_I),
    .rst_n_i(RST_N_I),
    .d_i({link_tgl, ENTER_I, START_I}),
    .q_o({tgl_s, enter_s, start_s})
  );

  // Character capture: held data is stable once toggle seen
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      tgl_d_reg <= 1'b0;
      enter_d_reg <= 1'b0;
      start_d_reg <= 1'b0;
      ch_reg <= 8'h00;
      ch_vld_reg <= 1'b0;
    end else begin
      tgl_d_reg <= tgl_s;
      enter_d_reg <= enter_s;
      start_d_reg <= start_s;
      ch_vld_reg <= (tgl_s != tgl_d_reg);
      if (tgl_s != tgl_d_reg)
        ch_reg <= link_char;
    end
  end

  wire start_ev = start_s && !start_d_reg;
  wire enter_ev = enter_s && !enter_d_reg;
  wire ch_hex = is_hex(ch_reg);
  wire [3:0] ch_nib = hex_val(ch_reg);
  wire [7:0] acc_next = {acc_reg[3:0], ch_nib};
  wire last_addr = (addr_reg == end_reg);

  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      step_cnt_reg <= '0;
      STEP_DRIVE_O <= ptd_pkg::PHASE_RESET;
    end else if (st_reg == ptd_pkg::ST_HEAD || st_reg == ptd_pkg::ST_DATA)
    begin
      if (step_cnt_reg == ptd_pkg::CNT_W'(ptd_pkg::STEP_CYC - 1)) begin
        step_cnt_reg <= '0;
        STEP_DRIVE_O <= {STEP_DRIVE_O[2:0], STEP_DRIVE_O[3]};
      end else begin
        step_cnt_reg <= step_cnt_reg + 1'b1;
      end
    end
  end

  // Main sequencer
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      st_reg <= ptd_pkg::ST_IDLE;
      rs_reg <= ptd_pkg::RS_MARK;
      fmt_reg <= 3'h0;
      cmp_reg <= 1'b0;
      nib_reg <= 1'b0;
      addr_reg <= 16'h0000;
      end_reg <= 16'h0000;
      acc_reg <= 8'h00;
      sum_reg <= 8'h00;
      cnt_reg <= 8'h00;
      pos_reg <= 4'h0;
      half_reg <= 1'b0;
      inword_reg <= 1'b0;
      exp_reg <= 8'h00;
      pend_cmp_reg <= 1'b0;
      pend_wr_reg <= 1'b0;
      ERROR_CODE_O <= 8'h00;
      WARBLE_O <= 1'b0;
      SHOW_ADDR_O <= 16'h0000;
      SHOW_DATA_O <= 8'h00;
      BUF_WDATA_O <= 8'h00;
    end else begin
      pend_cmp_reg <= 1'b0;
      pend_wr_reg <= 1'b0;
      // Word landed: write or compare, then advance
      if (pend_wr_reg) begin
        addr_reg <= addr_reg + 16'h0001;
        if (cmp_reg && exp_reg != BUF_WDATA_O) begin
          SHOW_ADDR_O <= addr_reg;
          SHOW_DATA_O <= exp_reg;
          st_reg <= ptd_pkg::ST_MISM;
        end else if (last_addr && fmt_reg != 3'h3) begin
          st_reg <= ptd_pkg::ST_DONE;
        end
      end
      case (st_reg)
        ptd_pkg::ST_IDLE: begin
          if (start_ev) begin
            fmt_reg <= FORMAT_I[2:1] == 2'h3 ? 3'h3 : {1'b0, FORMAT_I[2:1]};
            cmp_reg <= FORMAT_I[0];
            nib_reg <= NIBBLE_MODE_I;
            addr_reg <= START_ADDR_I;
            end_reg <= END_ADDR_I;
            rs_reg <= ptd_pkg::RS_MARK;
            half_reg <= 1'b0;
            inword_reg <= 1'b0;
            ERROR_CODE_O <= 8'h00;
            WARBLE_O <= 1'b0;
            st_reg <= FORMAT_I[2:1] == 2'h3 ? ptd_pkg::ST_DATA
              : ptd_pkg::ST_HEAD;
          end
        end
        ptd_pkg::ST_HEAD: begin
          if (ch_vld_reg && ((fmt_reg == 3'h0 && ch_reg == ptd_pkg::CH_STAR)
              || (fmt_reg == 3'h2 && ch_reg == ptd_pkg::CH_DELETE)
              || fmt_reg == 3'h1))
            st_reg <= ptd_pkg::ST_DATA;
          if (ch_vld_reg && fmt_reg == 3'h1 && ch_reg == ptd_pkg::CH_B) begin
            inword_reg <= 1'b1;
            pos_reg <= 4'h0;
          end
        end
        ptd_pkg::ST_DATA: begin
          if (ch_vld_reg && !pend_wr_reg && !pend_cmp_reg) begin
            case (fmt_reg)
              3'h0: begin
                if (ch_reg == ptd_pkg::CH_SLASH) begin
                  st_reg <= ptd_pkg::ST_DONE;
                end else if (ch_hex) begin
                  if (nib_reg || half_reg) begin
                    exp_reg <= nib_reg ? {4'h0, ch_nib} : acc_next;
                    pend_cmp_reg <= 1'b1;
                    half_reg <= 1'b0;
                  end else begin
                    acc_reg <= {4'h0, ch_nib};
                    half_reg <= 1'b1;
                  end
                end
              end
              3'h1: begin
                // B then eight letters (four in 4-bit mode) then F
                if (!inword_reg) begin
                  if (ch_reg == ptd_pkg::CH_B) begin
                    inword_reg <= 1'b1;
                    pos_reg <= 4'h0;
                    acc_reg <= 8'h00;
                  end
                end else if (pos_reg == (nib_reg ? 4'h4 : 4'h8)) begin
                  inword_reg <= 1'b0;
                  if (ch_reg == ptd_pkg::CH_F) begin
                    exp_reg <= acc_reg;
                    pend_cmp_reg <= 1'b1;
                  end
                end else if (ch_reg == ptd_pkg::CH_P ||
                    ch_reg == ptd_pkg::CH_N) begin
                  // P one, N zero, MSB first
                  acc_reg <= {acc_reg[6:0], ch_reg == ptd_pkg::CH_P};
                  pos_reg <= pos_reg + 4'h1;
                end else begin
                  inword_reg <= 1'b0;
                end
              end
              3'h2: begin
                // low four bits in 4-bit mode
                exp_reg <= nib_reg ? {4'h0, ch_reg[3:0]} : ch_reg;
                pend_cmp_reg <= 1'b1;
              end
              default: begin
                case (rs_reg)
                  ptd_pkg::RS_MARK: begin
                    if (ch_reg == ptd_pkg::CH_COLON) begin
                      rs_reg <= ptd_pkg::RS_LEN;
                      half_reg <= 1'b0;
                      sum_reg <= 8'h00;
                      pos_reg <= 4'h0;
                    end
                  end
                  default: begin
                    if (ch_hex) begin
                      half_reg <= ~half_reg;
                      acc_reg <= acc_next;
                      if (half_reg) begin
                        sum_reg <= sum_reg + acc_next;
                        pos_reg <= pos_reg + 4'h1;
                        case (rs_reg)
                          ptd_pkg::RS_LEN: begin
                            cnt_reg <= acc_next;
                            rs_reg <= ptd_pkg::RS_ADDR;
                            pos_reg <= 4'h0;
                          end
                          ptd_pkg::RS_ADDR: begin
                            addr_reg <= {addr_reg[7:0], acc_next};
                            if (pos_reg == 4'h1)
                              rs_reg <= ptd_pkg::RS_TYPE;
                          end
                          ptd_pkg::RS_TYPE: begin
                            rs_reg <= cnt_reg == 8'h00 ? ptd_pkg::RS_SUM
                              : ptd_pkg::RS_DATA;
                          end
                          ptd_pkg::RS_DATA: begin
                            exp_reg <= acc_next;
                            pend_cmp_reg <= 1'b1;
                            cnt_reg <= cnt_reg - 8'h01;
                            if (cnt_reg == 8'h01)
                              rs_reg <= ptd_pkg::RS_SUM;
                          end
                          default: begin
                            if (sum_reg + acc_next != 8'h00 && !cmp_reg) begin
                              ERROR_CODE_O <= ptd_pkg::CHECKSUM_ERROR_CODE;
                              WARBLE_O <= AUDIO_EN_I;
                            end
                            rs_reg <= ptd_pkg::RS_MARK;
                            if (addr_reg == end_reg + 16'h0001)
                              st_reg <= ptd_pkg::ST_DONE;
                          end
                        endcase
                      end
                    end
                  end
                endcase
              end
            endcase
          end
          // Buffer read settles, then merge nibble
          if (pend_cmp_reg) begin
            BUF_WDATA_O <= cmp_reg ? BUF_RDATA_I
              : nib_reg ? {BUF_RDATA_I[7:4], exp_reg[3:0]} : exp_reg;
            if (cmp_reg && nib_reg)
              exp_reg <= {BUF_RDATA_I[7:4], exp_reg[3:0]};
            pend_wr_reg <= 1'b1;
          end
        end
        ptd_pkg::ST_MISM: begin
          if (enter_ev)
            st_reg <= SHOW_ADDR_O == end_reg ? ptd_pkg::ST_DONE
              : ptd_pkg::ST_DATA;
        end
        ptd_pkg::ST_DONE: begin
          if (start_ev)
            st_reg <= ptd_pkg::ST_IDLE;
        end
        default: st_reg <= ptd_pkg::ST_IDLE;
      endcase
    end
  end

  assign BUF_ADDR_O = addr_reg;
  assign BUF_WE_O = pend_wr_reg && !cmp_reg;
  assign BUSY_O = (st_reg != ptd_pkg::ST_IDLE) && (st_reg != ptd_pkg::ST_DONE);
  assign DONE_O = (st_reg == ptd_pkg::ST_DONE);
  assign CMP_PAUSE_O = (st_reg == ptd_pkg::ST_MISM);
endmodule

// [logic/ptd_link.sv]
// Link-clock side: catches a character on each sprocket and hands it over
`timescale 1ns/1ns
module ptd_link (
  // Link clock domain
  input wire logic link_clk_i,
  input wire logic rst_n_i,
  input wire logic sprocket_i,
  input wire logic [7:0] data_i,
  // Toggle event and held character, read in the core domain
  output logic tgl_o,
  output logic [7:0] char_o
);
  logic spr_s;
  logic [7:0] data_s;
  logic spr_d_reg;
  // Reader pins pass two flops, same depth keeps data aligned
  ptd_sync #(.W(9)) u_pin_sync (
    .clk_i(link_clk_i),
    .rst_n_i(rst_n_i),
    .d_i({sprocket_i, data_i}),
    .q_o({spr_s, data_s})
  );
  always_ff @(posedge link_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      spr_d_reg <= 1'b0;
      tgl_o <= 1'b0;
      char_o <= 8'h00;
    end else begin
      spr_d_reg <= spr_s;
      if (spr_s && !spr_d_reg) begin
        char_o <= data_s;
        tgl_o <= ~tgl_o;
      end
    end
  end
endmodule

// [logic/ptd_pkg.sv]
// Shared constants and types for the paper tape format decoder
package ptd_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  // Format codes keyed in on the front panel
  localparam logic [7:0] FMT_HEX_DUP = 8'h00;
  localparam logic [7:0] FMT_HEX_CMP = 8'h01;
  localparam logic [7:0] FMT_LET_DUP = 8'h02;
  localparam logic [7:0] FMT_LET_CMP = 8'h03;
  localparam logic [7:0] FMT_BIN_DUP = 8'h04;
  localparam logic [7:0] FMT_BIN_CMP = 8'h05;
  localparam logic [7:0] FMT_REC_DUP = 8'h06;
  localparam logic [7:0] FMT_REC_CMP = 8'h07;
  // Special tape characters
  localparam logic [7:0] CH_STAR = 8'h2A;
  localparam logic [7:0] CH_SLASH = 8'h2F;
  localparam logic [7:0] CH_COLON = 8'h3A;
  localparam logic [7:0] CH_DELETE = 8'hFF;
  localparam logic [7:0] CH_B = 8'h42;
  localparam logic [7:0] CH_F = 8'h46;
  localparam logic [7:0] CH_N = 8'h4E;
  localparam logic [7:0] CH_P = 8'h50;
  localparam logic [7:0] REC_TYPE_DATA = 8'h00;
  // Error code shown on checksum failure
  localparam logic [7:0] CHECKSUM_ERROR_CODE = 8'hE6;
  // Reader stepping: drive pattern held per step
  localparam int STEP_NS = 2000;
  localparam int CLK_NS = 10;
  localparam int STEP_CYC = (STEP_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] PHASE_RESET = 4'h1;
  localparam int CNT_W = 12;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_HEAD = 3'h1,
    ST_DATA = 3'h3,
    ST_MISM = 3'h2,
    ST_DONE = 3'h7
  } ptd_state_t;
  typedef enum logic [2:0] {
    RS_MARK = 3'h0,
    RS_LEN = 3'h1,
    RS_ADDR = 3'h3,
    RS_TYPE = 3'h2,
    RS_DATA = 3'h6,
    RS_SUM = 3'h7
  } ptd_rec_t;
endpackage

// [logic/ptd_sync.sv]
// Two-flop level synchroniser
`timescale 1ns/1ns
module ptd_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Data
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_reg;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_reg <= '0;
      q_o <= '0;
    end else begin
      meta_reg <= d_i;
      q_o <= meta_reg;
    end
  end
endmodule

// [testbench/paper_tape_format_decoder_tb.sv]
// Self-checking bench for the paper tape format decoder
`timescale 1ns/1ns
module paper_tape_format_decoder_tb;
  typedef struct {logic [7:0] fmt; logic nib; logic [15:0] sa;
    logic [15:0] ea; string tape; logic [31:0] exp; int n;} ptd_row_t;
  logic clk = 1'b0, rst_n = 1'b0, tclk = 1'b0, start = 1'b0, enter = 1'b0;
  logic nib = 1'b0, aud = 1'b0, busy, done, pause, warble, bwe, spr;
  logic [7:0] fmt = 8'h00, tdat, sdata, ecode, bwd, brd;
  logic [15:0] sa = 16'h0000, ea = 16'h0000, saddr, baddr;
  logic [3:0] step;
  logic [7:0] mem [0:65535];
  int errors = 0, checked = 0, i, r, k;
  ptd_row_t rows [0:11];
  always #5 clk = ~clk;
  initial begin
    #37;
    forever #80 tclk = ~tclk;
  end
  assign brd = mem[baddr];
  always @(posedge clk) if (bwe) mem[baddr] <= bwd;
  ptd_tape_model u_tape (.tape_clk_i(tclk), .sprocket_o(spr), .data_o(tdat));
  ptd_decoder u_dut (.CLOCK_I(clk), .RST_N_I(rst_n), .TAPE_CLK_I(tclk),
    .SPROCKET_I(spr), .TAPE_DATA_I(tdat), .STEP_DRIVE_O(step),
    .START_I(start), .ENTER_I(enter), .FORMAT_I(fmt), .NIBBLE_MODE_I(nib),
    .AUDIO_EN_I(aud), .START_ADDR_I(sa), .END_ADDR_I(ea), .BUSY_O(busy),
    .DONE_O(done), .CMP_PAUSE_O(pause), .SHOW_ADDR_O(saddr),
    .SHOW_DATA_O(sdata), .ERROR_CODE_O(ecode), .WARBLE_O(warble),
    .BUF_ADDR_O(baddr), .BUF_WDATA_O(bwd), .BUF_WE_O(bwe),
    .BUF_RDATA_I(brd));
  task stop_test();
    if (errors == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Start (0) or enter (1) key press, held past the synchroniser
  task kick(input logic which);
    @(negedge clk);
    if (which) enter = 1'b1;
    else start = 1'b1;
    repeat (6) @(negedge clk);
    start = 1'b0;
    enter = 1'b0;
    repeat (6) @(negedge clk);
  endtask
  // Wait for done (0) or pause (1)
  task wait_on(input logic which);
    int w;
    for (w = 0; w < 30000; w++) begin
      if ((which ? pause : done) === 1'b1) break;
      @(negedge clk);
    end
    if (w == 30000) begin
      errors++;
      $display("[ERR] %0t wait timed out", $time);
      stop_test();
    end
  endtask
  task send_str(input string s, input int gap);
    for (int j = 0; j < s.len(); j++) u_tape.send(s[j], gap);
    repeat (40) @(negedge clk);
  endtask
  initial begin
    for (i = 0; i < 256; i++) mem[i] = 8'h70;
    rows = '{
    '{8'h00,1'b0,16'h10,16'h12,"AB*12 AB\n3C",32'h12AB3C00,3},
    '{8'h00,1'b1,16'h20,16'h21,"*9C",32'h797C0000,2},
    '{8'h00,1'b0,16'h30,16'h33,"*11/22",32'h11700000,2},
    '{8'h02,1'b0,16'h40,16'h41," BPNNPPPNPF BNNNNNNNPF",32'h9D010000,2},
    '{8'h02,1'b1,16'h50,16'h50," BPNPPF",32'h7B000000,1},
    '{8'h04,1'b0,16'h60,16'h62,"\001\377/\377*",32'h2FFF2A00,3},
    '{8'h04,1'b1,16'h70,16'h70,"\377\254",32'h7C000000,1},
    '{8'h06,1'b0,16'h80,16'h82,"z:02008000123438:01008200ABD2",32'h1234AB00,3},
    '{8'h01,1'b0,16'hA0,16'hA0,"*70",32'h70000000,1},
    '{8'h03,1'b0,16'hA1,16'hA1," BNPPPNNNNF",32'h70000000,1},
    '{8'h05,1'b0,16'hA2,16'hA3,"\377pp",32'h70700000,2},
    '{8'h07,1'b0,16'hA4,16'hA4,":0100A40070EB",32'h70000000,1}};
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    for (r = 0; r < 12; r++) begin
      fmt = rows[r].fmt;
      nib = rows[r].nib;
      sa = rows[r].sa;
      ea = rows[r].ea;
      kick(1'b0);
      send_str(rows[r].tape, r % 3);
      wait_on(1'b0);
      for (k = 0; k < rows[r].n; k++)
        chk(
          {8'h00, mem[sa + k]},
          {8'h00, rows[r].exp[8*(3-k) +: 8]});
      chk({8'h00, ecode}, 16'h0000);
      kick(1'b0);
    end
    // Compare mismatch, pause, enter, resume
    fmt = 8'h01;
    sa = 16'h0090;
    ea = 16'h0092;
    kick(1'b0);
    send_str("*70 71", 1);
    wait_on(1'b1);
    chk(saddr, 16'h0091);
    chk({8'h00, sdata}, 16'h0071);
    kick(1'b1);
    send_str("75", 0);
    wait_on(1'b1);
    chk(saddr, 16'h0092);
    chk({8'h00, sdata}, 16'h0075);
    kick(1'b1);
    wait_on(1'b0);
    chk({8'h00, mem[16'h0092]}, 16'h0070);
    chk({8'h00, mem[16'h0091]}, 16'h0070);
    kick(1'b0);
    // Bad record checksum with audio on
    fmt = 8'h06;
    aud = 1'b1;
    sa = 16'h0080;
    ea = 16'h0081;
    kick(1'b0);
    send_str(":02008000123439", 0);
    for (i = 0; i < 300 && ecode !== 8'hE6; i++) @(negedge clk);
    chk({8'h00, ecode}, {8'h00, ptd_pkg::CHECKSUM_ERROR_CODE});
    chk({15'h0000, warble}, 16'h0001);
    // Reset after the failed run ends, error code and tone still set
    rst_n = 1'b0;
    repeat (20) @(negedge clk);
    chk({12'h000, step}, 16'h0001);
    chk({8'h00, ecode}, 16'h0000);
    chk({13'h0000, warble, busy, pause}, 16'h0000);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    stop_test();
  end
endmodule

// [testbench/ptd_monitor.sv]
// Assertion checker for the paper tape format decoder ports
`timescale 1ns/1ns
module ptd_monitor (
  // Clock, reset and panel inputs
  input wire logic CLOCK_I,
  input wire logic RST_N_I,
  input wire logic ENTER_I,
  input wire logic AUDIO_EN_I,
  input wire logic [7:0] FORMAT_I,
  input wire logic [15:0] START_ADDR_I,
  // Design outputs
  input wire logic [3:0] STEP_DRIVE_O,
  input wire logic BUSY_O,
  input wire logic CMP_PAUSE_O,
  input wire logic [15:0] SHOW_ADDR_O,
  input wire logic [7:0] SHOW_DATA_O,
  input wire logic [7:0] ERROR_CODE_O,
  input wire logic WARBLE_O,
  input wire logic [15:0] BUF_ADDR_O,
  input wire logic BUF_WE_O
);
  logic [3:0] step_reg;
  logic [15:0] last_reg;
  logic seen_reg;
  logic enter_reg;
  logic [7:0] fmt_reg;
  logic rec_w;
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (!RST_N_I);
  assign rec_w = (fmt_reg[2:1] == 2'h3);
  // Previous step pattern, first write seen, enter seen in pause
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      step_reg <= 4'h1;
      last_reg <= 16'h0000;
      seen_reg <= 1'b0;
      enter_reg <= 1'b0;
      fmt_reg <= 8'h00;
    end else begin
      step_reg <= STEP_DRIVE_O;
      if (BUF_WE_O) last_reg <= BUF_ADDR_O;
      seen_reg <= BUF_WE_O | (seen_reg & BUSY_O);
      enter_reg <= CMP_PAUSE_O & (enter_reg | ENTER_I);
      if (!BUSY_O) fmt_reg <= FORMAT_I;
    end
  end
  sequence s_held;
    CMP_PAUSE_O ##1 CMP_PAUSE_O;
  endsequence
  a_step_onehot: assert property ($onehot(STEP_DRIVE_O))
    else $error("step drive not one-hot");
  a_step_idle: assert property (!BUSY_O [*3] |-> $stable(STEP_DRIVE_O))
    else $error("step drive moved while idle");
  a_step_rotate: assert property ($changed(STEP_DRIVE_O) |->
    STEP_DRIVE_O == {step_reg[2:0], step_reg[3]} ||
    STEP_DRIVE_O == {step_reg[0], step_reg[3:1]})
    else $error("step drive did not rotate by one");
  a_we_pulse: assert property (BUF_WE_O |=> !BUF_WE_O)
    else $error("buffer write longer than one cycle");
  a_cmp_nowrite: assert property (BUF_WE_O |-> !fmt_reg[0])
    else $error("buffer written in compare mode");
  a_first_addr: assert property (BUF_WE_O && !seen_reg && !rec_w
    |-> BUF_ADDR_O == START_ADDR_I)
    else $error("first write not at start address");
  a_addr_incr: assert property (BUF_WE_O && seen_reg && !rec_w
    |-> BUF_ADDR_O == last_reg + 16'h0001)
    else $error("write address did not increment");
  a_err_value: assert property (ERROR_CODE_O inside {8'h00, 8'hE6})
    else $error("unexpected error code");
  a_warble_cause: assert property ($rose(WARBLE_O) |->
    ERROR_CODE_O == ptd_pkg::CHECKSUM_ERROR_CODE && AUDIO_EN_I)
    else $error("tone without checksum error or audio");
  a_pause_exit: assert property ($fell(CMP_PAUSE_O) |-> enter_reg)
    else $error("pause left without enter");
  a_pause_show: assert property (s_held |-> $stable(SHOW_ADDR_O) &&
    $stable(SHOW_DATA_O) && !BUF_WE_O)
    else $error("shown mismatch changed during pause");
endmodule

bind ptd_decoder ptd_monitor u_mon (.CLOCK_I(CLOCK_I), .RST_N_I(RST_N_I),
  .ENTER_I(ENTER_I), .AUDIO_EN_I(AUDIO_EN_I), .FORMAT_I(FORMAT_I),
  .START_ADDR_I(START_ADDR_I), .STEP_DRIVE_O(STEP_DRIVE_O), .BUSY_O(BUSY_O),
  .CMP_PAUSE_O(CMP_PAUSE_O), .SHOW_ADDR_O(SHOW_ADDR_O),
  .SHOW_DATA_O(SHOW_DATA_O), .ERROR_CODE_O(ERROR_CODE_O),
  .WARBLE_O(WARBLE_O), .BUF_ADDR_O(BUF_ADDR_O), .BUF_WE_O(BUF_WE_O));

// [testbench/ptd_tape_model.sv]
// Behavioural parallel tape reader: sprocket and data lines
`timescale 1ns/1ns
module ptd_tape_model (
  // Link clock
  input wire logic tape_clk_i,
  // Reader lines
  output logic sprocket_o,
  output logic [7:0] data_o
);
  initial begin
    sprocket_o = 1'b0;
    data_o = 8'h00;
  end
  task automatic send(input logic [7:0] c, input int gap);
    @(negedge tape_clk_i);
    data_o = c;
    @(negedge tape_clk_i);
    sprocket_o = 1'b1;
    @(negedge tape_clk_i);
    sprocket_o = 1'b0;
    @(negedge tape_clk_i);
    data_o = ~c;
    repeat (gap) @(negedge tape_clk_i);
  endtask
endmodule
